// ==== mcsos_clk_stab.sv ====
// Main clock select, stabilization status and wait-time select registers.
// Assumes a byte-wide special-function register port on the system clock,
// stop and halt controls from the same clock, and X1 pins from outside.
`timescale 1ns/1ps
`default_nettype none
module mcsos_clk_stab (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic [mcsos_pkg::ADDR_W-1:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic i_sfr_bit,
	input wire logic [2:0] i_sfr_bit_idx,
	input wire logic [mcsos_pkg::DATA_W-1:0] i_sfr_wdata,
	output logic [mcsos_pkg::DATA_W-1:0] o_sfr_rdata,
	input wire logic i_x1_clk,
	input wire logic i_x1_osc_run,
	input wire logic i_x1_halt,
	input wire logic i_stop_exec,
	input wire logic i_stop_release,
	input wire logic i_timer8_slow_sel,
	input wire logic i_periph_ext_sel,
	input wire logic i_tm16_ext_sel,
	output logic o_main_clk_hs,
	output logic o_periph_clk_hs,
	output logic o_own_clk_bypass,
	output logic o_wdog_own_clk,
	output logic o_cpu_hold
);
	import mcsos_pkg::*;

	mcsos_cnt_if cif ();

	logic pick_reg, pick_next;
	logic src_reg, src_next;
	logic lock_reg, lock_next;
	logic [CODE_W-1:0] wsel_reg, wsel_next;
	logic main_hs_reg, main_hs_next;
	logic periph_hs_reg, periph_hs_next;
	logic bypass_reg, bypass_next;
	logic wdog_reg, wdog_next;
	logic hold_reg, hold_next;
	logic lim_reg, lim_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	mcsos_state_e state_reg, state_next;
	logic src_we;
	logic src_wr;
	logic wr_mode;
	logic wr_wait;
	logic [DATA_W-1:0] mode_view;

	assign wr_mode = i_sfr_wr && (i_sfr_addr == ADDR_MODE);
	assign wr_wait = i_sfr_wr && (i_sfr_addr == ADDR_WAIT);

	mcsos_stab_cnt u_cnt (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_x1_clk(i_x1_clk),
		.i_x1_osc_run(i_x1_osc_run),
		.cif(cif)
	);

	// Stop entry and a halted X1 both restart the count from zero.
	assign cif.clr = i_stop_exec | i_x1_halt;
	assign cif.run = (state_reg != ST_STOP);
	assign cif.limit = lim_reg ? mcsos_wait_limit(wsel_reg) : T16;

	// Register writes.
	always_comb begin
		pick_next = pick_reg;
		src_next = src_reg;
		lock_next = lock_reg;
		wsel_next = wsel_reg;
		src_we = 1'b0;
		src_wr = src_reg;
		if (wr_mode) begin
			if (!i_sfr_bit) begin
				pick_next = i_sfr_wdata[MODE_PICK_BIT];
				src_we = 1'b1;
				src_wr = i_sfr_wdata[MODE_SRC_BIT];
			end else if (i_sfr_bit_idx == MODE_PICK_BIT) begin
				pick_next = i_sfr_wdata[0];
			end else if (i_sfr_bit_idx == MODE_SRC_BIT) begin
				src_we = 1'b1;
				src_wr = i_sfr_wdata[0];
			end
		end
		// Switching back and forth could glitch the peripheral clock,
		// so the source select locks after its first change.
		if (src_we && !lock_reg && (src_wr != src_reg)) begin
			src_next = src_wr;
			lock_next = 1'b1;
		end
		if (wr_wait && !i_sfr_bit) begin
			wsel_next = i_sfr_wdata[CODE_W-1:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			pick_reg <= MODE_RST[MODE_PICK_BIT];
			src_reg <= MODE_RST[MODE_SRC_BIT];
			lock_reg <= 1'b0;
			wsel_reg <= WAIT_RST[CODE_W-1:0];
		end else begin
			pick_reg <= pick_next;
			src_reg <= src_next;
			lock_reg <= lock_next;
			wsel_reg <= wsel_next;
		end
	end

	// Clock routing outputs.
	always_comb begin
		main_hs_next = src_reg & pick_reg;
		periph_hs_next = src_reg;
		bypass_next = i_timer8_slow_sel |
			(i_periph_ext_sel & ~i_tm16_ext_sel);
		wdog_next = 1'b1;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			main_hs_reg <= 1'b0;
			periph_hs_reg <= 1'b0;
			bypass_reg <= 1'b0;
			wdog_reg <= 1'b0;
		end else begin
			main_hs_reg <= main_hs_next;
			periph_hs_reg <= periph_hs_next;
			bypass_reg <= bypass_next;
			wdog_reg <= wdog_next;
		end
	end

	// Stop sequencing and CPU hold.
	always_comb begin
		state_next = state_reg;
		hold_next = hold_reg;
		lim_next = lim_reg;
		case (state_reg)
			ST_RUN: begin
				if (i_stop_exec) begin
					state_next = ST_STOP;
					lim_next = 1'b1;
				end
			end
			ST_STOP: begin
				if (i_stop_release) begin
					state_next = ST_WAIT;
					hold_next = main_hs_reg;
				end
			end
			ST_WAIT: begin
				// A halted X1 would never finish, so it ends the wait.
				if (cif.done || i_x1_halt) begin
					state_next = ST_RUN;
					hold_next = 1'b0;
				end
			end
			default: begin
				state_next = ST_RUN;
				hold_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state_reg <= ST_RUN;
			hold_reg <= 1'b0;
			lim_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			hold_reg <= hold_next;
			lim_reg <= lim_next;
		end
	end

	// Register reads; unmapped addresses read zero.
	always_comb begin
		mode_view = '0;
		mode_view[MODE_PICK_BIT] = pick_reg;
		mode_view[MODE_STATE_BIT] = main_hs_reg;
		mode_view[MODE_SRC_BIT] = src_reg;
		rdata_next = rdata_reg;
		if (i_sfr_rd) begin
			case (i_sfr_addr)
				ADDR_MODE: rdata_next = mode_view;
				ADDR_STAT: rdata_next = {{(DATA_W-FLAG_W){1'b0}},
					cif.flags};
				ADDR_WAIT: rdata_next = {{(DATA_W-CODE_W){1'b0}},
					wsel_reg};
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign o_sfr_rdata = rdata_reg;
	assign o_main_clk_hs = main_hs_reg;
	assign o_periph_clk_hs = periph_hs_reg;
	assign o_own_clk_bypass = bypass_reg;
	assign o_wdog_own_clk = wdog_reg;
	assign o_cpu_hold = hold_reg;

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);

	property p_mode_reset;
		$rose(i_rst_n) |-> (!pick_reg && !src_reg && !main_hs_reg);
	endproperty
	a_mode_reset: assert property (p_mode_reset)
		else $error("Main clock mode register not cleared by reset.");

	property p_main_implies_periph;
		o_main_clk_hs |-> o_periph_clk_hs;
	endproperty
	a_main_implies_periph: assert property (p_main_implies_periph)
		else $error("Main clock on X1 while peripheral clock internal.");

	property p_state_bit;
		(i_sfr_rd && i_sfr_addr == ADDR_MODE) |=>
			(o_sfr_rdata[MODE_STATE_BIT] == $past(main_hs_reg));
	endproperty
	a_state_bit: assert property (p_state_bit)
		else $error("Status bit does not show the main clock source.");

	property p_src_once;
		lock_reg |=> $stable(src_reg);
	endproperty
	a_src_once: assert property (p_src_once)
		else $error("Clock source select changed twice.");

	property p_status_read;
		(i_sfr_rd && i_sfr_addr == ADDR_STAT) |=>
			(o_sfr_rdata == {3'h0, $past(cif.flags)});
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("Status read does not return the flags.");

	property p_stop_clears;
		i_stop_exec |=> (cif.flags == 5'h00);
	endproperty
	a_stop_clears: assert property (p_stop_clears)
		else $error("Stop entry did not clear the status.");

	property p_sticky;
		// A clear lands one cycle late, so the clear of the cycle before counts.
		!$past(cif.clr) |->
			((cif.flags & $past(cif.flags)) == $past(cif.flags));
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("A status flag fell without a clear.");

	property p_limited;
		(lim_reg && wsel_reg == CODE_W11) |-> (cif.flags[3:0] == 4'h0);
	endproperty
	a_limited: assert property (p_limited)
		else $error("A flag beyond the selected wait time set.");

	property p_hold_waits;
		(o_cpu_hold && !cif.done && !i_x1_halt) |=> o_cpu_hold;
	endproperty
	a_hold_waits: assert property (p_hold_waits)
		else $error("CPU released before the wait time elapsed.");

	property p_hold_release;
		(state_reg == ST_STOP && i_stop_release) |=>
			(o_cpu_hold == $past(o_main_clk_hs));
	endproperty
	a_hold_release: assert property (p_hold_release)
		else $error("CPU hold does not follow the clock in use at release.");

	property p_wait_done;
		(state_reg == ST_WAIT && cif.done) |=> !o_cpu_hold;
	endproperty
	a_wait_done: assert property (p_wait_done)
		else $error("CPU still held after the wait time elapsed.");

	property p_wdog_own;
		$past(i_rst_n) |-> o_wdog_own_clk;
	endproperty
	a_wdog_own: assert property (p_wdog_own)
		else $error("Watchdog not kept on its own clock.");

	property p_wait_reset;
		$rose(i_rst_n) |-> (wsel_reg == WAIT_RST[CODE_W-1:0]);
	endproperty
	a_wait_reset: assert property (p_wait_reset)
		else $error("Wait-time select did not reset to its default.");

	property p_bit_write_wait;
		(wr_wait && i_sfr_bit) |=> $stable(wsel_reg);
	endproperty
	a_bit_write_wait: assert property (p_bit_write_wait)
		else $error("Bit write changed the wait-time select.");

	c_src_switch: cover property ($rose(src_reg));
	c_flag_a: cover property ($rose(cif.flags[4]));
	c_wait_int: cover property (state_reg == ST_WAIT && !o_cpu_hold);
	c_stop_wait: cover property (state_reg == ST_WAIT ##1 state_reg == ST_RUN);
	c_hold: cover property ($fell(o_cpu_hold));
endmodule // mcsos_clk_stab
`default_nettype wire

// ==== mcsos_clk_stab_tb_top.sv ====
// Self-checking bench for the main clock select and X1 stabilization block.
// Assumes the design files are compiled first; the bench drives every input.
`timescale 1ns/1ps
`default_nettype none
module mcsos_clk_stab_tb_top;
	import mcsos_pkg::*;
	localparam int LIMIT = 80000;
	// The shortest wait, 2^11 X1 edges at a 20 ns X1 period, in 5 ns cycles.
	localparam int W11_CYC = 8192;
	// Sync latency and X1 phase make edge times fuzzy by a few cycles.
	localparam int SLACK = 40;
	logic i_mclk;
	logic i_rst_n;
	logic [ADDR_W-1:0] addr;
	logic wr, rd, bitop;
	logic [2:0] idx;
	logic [DATA_W-1:0] wdata, rdata;
	logic x1_clk, osc_run, halt, stop_exec, stop_rel, t8_slow, p_ext, t16_ext;
	logic main_hs, periph_hs, bypass, wdog, hold;
	int n_fail, comparisons, cyc;

	mcsos_clk_stab uut (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_sfr_addr(addr),
		.i_sfr_wr(wr),
		.i_sfr_rd(rd),
		.i_sfr_bit(bitop),
		.i_sfr_bit_idx(idx),
		.i_sfr_wdata(wdata),
		.o_sfr_rdata(rdata),
		.i_x1_clk(x1_clk),
		.i_x1_osc_run(osc_run),
		.i_x1_halt(halt),
		.i_stop_exec(stop_exec),
		.i_stop_release(stop_rel),
		.i_timer8_slow_sel(t8_slow),
		.i_periph_ext_sel(p_ext),
		.i_tm16_ext_sel(t16_ext),
		.o_main_clk_hs(main_hs),
		.o_periph_clk_hs(periph_hs),
		.o_own_clk_bypass(bypass),
		.o_wdog_own_clk(wdog),
		.o_cpu_hold(hold)
	);

	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	// X1 runs at a quarter of the system rate, off phase from it.
	initial begin
		x1_clk = 1'b0;
		#1.3;
		forever #10 x1_clk = ~x1_clk;
	end

	task automatic test_done();
		if (n_fail == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen,
			input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge i_mclk);
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d,
			input logic b, input logic [2:0] i);
		@(negedge i_mclk);
		addr = a;
		wdata = d;
		bitop = b;
		idx = i;
		wr = 1'b1;
		@(negedge i_mclk);
		wr = 1'b0;
	endtask

	// Read data is registered, so it is sampled a full cycle after the strobe.
	task automatic rd_chk(input string name, input logic [15:0] a,
			input logic [7:0] exp);
		@(negedge i_mclk);
		addr = a;
		bitop = 1'b0;
		rd = 1'b1;
		@(negedge i_mclk);
		rd = 1'b0;
		@(negedge i_mclk);
		chk(name, rdata, exp);
	endtask

	task automatic pulse(ref logic s);
		@(negedge i_mclk);
		s = 1'b1;
		@(negedge i_mclk);
		s = 1'b0;
	endtask

	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			test_done();
		end
	end

	initial begin
		{addr, wr, rd, bitop, idx, wdata} = '0;
		{osc_run, halt, stop_exec, stop_rel, t8_slow, p_ext, t16_ext} = '0;
		n_fail = 0;
		comparisons = 0;
		cyc = 0;
		i_rst_n = 1'b0;
		cycles(8);
		i_rst_n = 1'b1;
		cycles(1);
		chk("wdog", {7'h00, wdog}, 8'h01);
		rd_chk("mode_rst", ADDR_MODE, MODE_RST);
		rd_chk("wait_rst", ADDR_WAIT, WAIT_RST);
		rd_chk("stat_rst", ADDR_STAT, 8'h00);
		wr_reg(ADDR_STAT, 8'hFF, 1'b0, 3'h0);
		rd_chk("stat_ro", ADDR_STAT, 8'h00);
		wr_reg(16'hFFA2, 8'hFF, 1'b0, 3'h0);
		rd_chk("unmapped", 16'hFFA2, 8'h00);
		wr_reg(ADDR_WAIT, 8'h00, 1'b1, 3'h0);
		rd_chk("wait_bit", ADDR_WAIT, WAIT_RST);
		for (int k = 1; k <= 5; k++) begin
			wr_reg(ADDR_WAIT, 8'(k), 1'b0, 3'h0);
			rd_chk("wait_code", ADDR_WAIT, 8'(k));
		end
		for (int k = 0; k < 8; k++) begin
			{t8_slow, p_ext, t16_ext} = 3'(k);
			cycles(3);
			chk("bypass", {7'h00, bypass},
				{7'h00, t8_slow | (p_ext & ~t16_ext)});
		end
		{t8_slow, p_ext, t16_ext} = 3'h0;
		wr_reg(ADDR_MODE, 8'h03, 1'b0, 3'h0);
		rd_chk("mode_pick", ADDR_MODE, 8'h01);
		chk("clk_int", {6'h00, main_hs, periph_hs}, 8'h00);
		wr_reg(ADDR_MODE, 8'h00, 1'b0, 3'h0);
		wr_reg(ADDR_MODE, 8'h01, 1'b1, MODE_SRC_BIT);
		rd_chk("mode_src", ADDR_MODE, 8'h04);
		chk("clk_per", {6'h00, main_hs, periph_hs}, 8'h01);
		wr_reg(ADDR_MODE, 8'h01, 1'b1, MODE_PICK_BIT);
		rd_chk("mode_x1", ADDR_MODE, 8'h07);
		chk("clk_x1", {6'h00, main_hs, periph_hs}, 8'h03);
		wr_reg(ADDR_MODE, 8'h00, 1'b0, 3'h0);
		rd_chk("mode_lock", ADDR_MODE, 8'h04);
		wr_reg(ADDR_MODE, 8'h01, 1'b0, 3'h0);
		rd_chk("mode_x1b", ADDR_MODE, 8'h07);
		cycles(2000);
		rd_chk("osc_off", ADDR_STAT, 8'h00);
		osc_run = 1'b1;
		cycles(W11_CYC - SLACK);
		rd_chk("stab_early", ADDR_STAT, 8'h00);
		cycles(2 * SLACK);
		rd_chk("stab_a", ADDR_STAT, 8'h10);
		halt = 1'b1;
		cycles(2);
		rd_chk("stab_halt", ADDR_STAT, 8'h00);
		halt = 1'b0;
		wr_reg(ADDR_WAIT, 8'h01, 1'b0, 3'h0);
		cycles(W11_CYC - SLACK);
		rd_chk("restart_early", ADDR_STAT, 8'h00);
		cycles(2 * SLACK);
		rd_chk("restart_a", ADDR_STAT, 8'h10);
		pulse(stop_exec);
		rd_chk("stab_stop", ADDR_STAT, 8'h00);
		pulse(stop_rel);
		cycles(1);
		chk("hold_on", {7'h00, hold}, 8'h01);
		cycles(W11_CYC - 2 * SLACK);
		chk("hold_mid", {7'h00, hold}, 8'h01);
		cycles(3 * SLACK);
		chk("hold_off", {7'h00, hold}, 8'h00);
		rd_chk("stop_a", ADDR_STAT, 8'h10);
		// Past 2^13 X1 edges the second flag would be up without the limit.
		cycles(4 * W11_CYC + 200);
		rd_chk("stop_sat", ADDR_STAT, 8'h10);
		chk("hold_end", {7'h00, hold}, 8'h00);
		// Back on the internal clock the CPU keeps running and polls instead.
		wr_reg(ADDR_MODE, 8'h00, 1'b1, MODE_PICK_BIT);
		rd_chk("mode_int", ADDR_MODE, 8'h04);
		wr_reg(ADDR_WAIT, 8'h02, 1'b0, 3'h0);
		rd_chk("wait_long", ADDR_WAIT, 8'h02);
		pulse(stop_exec);
		pulse(stop_rel);
		cycles(1);
		chk("hold_int", {7'h00, hold}, 8'h00);
		cycles(W11_CYC - SLACK);
		rd_chk("poll_early", ADDR_STAT, 8'h00);
		cycles(2 * SLACK);
		rd_chk("poll_a", ADDR_STAT, 8'h10);
		chk("hold_int_end", {7'h00, hold}, 8'h00);
		test_done();
	end
endmodule // mcsos_clk_stab_tb_top
`default_nettype wire

// ==== mcsos_cnt_if.sv ====
// Interface between the clock-select control and the stabilization counter.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
`default_nettype none
interface mcsos_cnt_if;
	logic clr;
	logic run;
	logic [mcsos_pkg::CNT_W-1:0] limit;
	logic [mcsos_pkg::FLAG_W-1:0] flags;
	logic done;
	modport ctl(output clr, output run, output limit, input flags, input done);
	modport cnt(input clr, input run, input limit, output flags, output done);
endinterface
`default_nettype wire

// ==== mcsos_pkg.sv ====
// Constants, register map and types for the main clock select and X1
// stabilization block.
// Assumes an 8-bit special-function register port on the system clock.
package mcsos_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int CNT_W = 17;
	localparam int FLAG_W = 5;
	localparam int CODE_W = 3;
	localparam logic [15:0] ADDR_MODE = 16'hFFA1;
	localparam logic [15:0] ADDR_STAT = 16'hFFA3;
	localparam logic [15:0] ADDR_WAIT = 16'hFFA4;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] WAIT_RST = 8'h05;
	localparam logic [2:0] MODE_PICK_BIT = 3'h0;
	localparam logic [2:0] MODE_STATE_BIT = 3'h1;
	localparam logic [2:0] MODE_SRC_BIT = 3'h2;
	localparam logic [2:0] CODE_W11 = 3'h1;
	localparam logic [2:0] CODE_W13 = 3'h2;
	localparam logic [2:0] CODE_W14 = 3'h3;
	localparam logic [2:0] CODE_W15 = 3'h4;
	localparam logic [2:0] CODE_W16 = 3'h5;
	localparam logic [16:0] T11 = 17'h00800;
	localparam logic [16:0] T13 = 17'h02000;
	localparam logic [16:0] T14 = 17'h04000;
	localparam logic [16:0] T15 = 17'h08000;
	localparam logic [16:0] T16 = 17'h10000;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_STOP,
		ST_WAIT
	} mcsos_state_e;

	// Prohibited codes fall back to the longest wait, the safe side.
	function automatic logic [16:0] mcsos_wait_limit(input logic [2:0] code);
		logic [16:0] lim;
		lim = T16;
		case (code)
			CODE_W11: lim = T11;
			CODE_W13: lim = T13;
			CODE_W14: lim = T14;
			CODE_W15: lim = T15;
			CODE_W16: lim = T16;
			default: lim = T16;
		endcase
		return lim;
	endfunction
endpackage

// ==== mcsos_stab_cnt.sv ====
// X1 oscillation stabilization counter with pin synchronisers.
// Assumes X1 runs well below half the system clock rate.
`timescale 1ns/1ps
`default_nettype none
module mcsos_stab_cnt (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_x1_clk,
	input wire logic i_x1_osc_run,
	mcsos_cnt_if.cnt cif
);
	import mcsos_pkg::*;

	logic x1_meta_reg, x1_meta_next;
	logic x1_sync_reg, x1_sync_next;
	logic x1_prev_reg, x1_prev_next;
	logic osc_meta_reg, osc_meta_next;
	logic osc_sync_reg, osc_sync_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic x1_rise;

	assign x1_rise = x1_sync_reg & ~x1_prev_reg;

	always_comb begin
		x1_meta_next = i_x1_clk;
		x1_sync_next = x1_meta_reg;
		x1_prev_next = x1_sync_reg;
		osc_meta_next = i_x1_osc_run;
		osc_sync_next = osc_meta_reg;
		cnt_next = cnt_reg;
		if (cif.clr) begin
			cnt_next = '0;
		end else if (cif.run && osc_sync_reg && x1_rise &&
				cnt_reg < cif.limit) begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			x1_meta_reg <= 1'b0;
			x1_sync_reg <= 1'b0;
			x1_prev_reg <= 1'b0;
			osc_meta_reg <= 1'b0;
			osc_sync_reg <= 1'b0;
			cnt_reg <= '0;
		end else begin
			x1_meta_reg <= x1_meta_next;
			x1_sync_reg <= x1_sync_next;
			x1_prev_reg <= x1_prev_next;
			osc_meta_reg <= osc_meta_next;
			osc_sync_reg <= osc_sync_next;
			cnt_reg <= cnt_next;
		end
	end

	// Flags are thresholds on a counter that only grows until cleared, so they stay set until a clear.
	assign cif.flags = {cnt_reg >= T11, cnt_reg >= T13, cnt_reg >= T14,
		cnt_reg >= T15, cnt_reg >= T16};
	assign cif.done = cnt_reg >= cif.limit;

	property p_no_osc_no_count;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(!osc_sync_reg && !cif.clr) |=> $stable(cnt_reg);
	endproperty
	a_no_osc_no_count: assert property (p_no_osc_no_count)
		else $error("Counter moved before X1 oscillation started.");

	property p_saturate;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(cif.done && !cif.clr) |=> (cnt_reg == $past(cnt_reg));
	endproperty
	a_saturate: assert property (p_saturate)
		else $error("Counter went past its limit.");
endmodule // mcsos_stab_cnt
`default_nettype wire
